// [pkg/mode_ctrl_pkg.sv]
package mode_ctrl_pkg;
   // ==========================================
   // processor mode register layout
   localparam int PM_WIDTH = 8;
   localparam int PM_MODE_LO = 0;
   localparam int PM_MODE_HI = 1;
   localparam int PM_SOFT_RST_BIT = 3;
   localparam logic [15:0] PM_ADDR = 16'h0004;
   localparam logic [7:0] PM_RESET_VAL = 8'h00;
   // ==========================================
   // processor mode field codes
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_EXPAND = 2'h1;
   localparam logic [1:0] MODE_BAD = 2'h2;
   localparam logic [1:0] MODE_MICRO = 2'h3;
   // ==========================================
   // soft reset pulse length in cycles
   localparam int SOFT_RST_CYCLES = 4;
   localparam logic [2:0] SOFT_RST_LAST = 3'h3;
   // access space codes
   typedef enum logic [1:0] {SPACE_SFR, SPACE_RAM, SPACE_ROM, SPACE_EXT} space_t;
endpackage

// [design/soft_reset_gen.sv]
`timescale 1ns/1ps
`default_nettype none
// stretches a one-cycle software reset request into a reset pulse
module soft_reset_gen
   import mode_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic trigger,
   output logic soft_rst
);
   // ==========================================
   // state
   typedef struct packed
   {
      logic busy;
      logic [2:0] count;
   } gen_state_t;

   gen_state_t st_reg;
   gen_state_t st_next;

   // count the pulse up to SOFT_RST_LAST once triggered
   always_comb
   begin
      st_next = st_reg;
      if (trigger && !st_reg.busy)
      begin
         st_next.busy = 1'b1;
         st_next.count = 3'h0;
      end
      else if (st_reg.busy)
      begin
         if (st_reg.count == SOFT_RST_LAST)
            st_next.busy = 1'b0;
         else
            st_next.count = st_reg.count + 3'h1;
      end
   end

   // only the hardware reset clears this one; it must outlive the pulse
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign soft_rst = st_reg.busy;
endmodule
`default_nettype wire

// [design/processor_mode_and_soft_reset.sv]
`timescale 1ns/1ps
`default_nettype none
module processor_mode_and_soft_reset
   import mode_ctrl_pkg::*;
#(
   parameter int NUM_PORTS = 11
)
(
   // clock and raw reset from the pins
   input wire logic ref_clk,
   input wire logic resetn, // async, active low
   // strap level, asynchronous to the clock
   input wire logic boot_mode_pin,
   // mode register write port and readback
   input wire logic pm_wr, // one-cycle strobe
   input wire logic [7:0] pm_wdata,
   output logic [7:0] pm_rdata, // bit 3 always reads 0
   // access request judged against the mode
   input wire logic acc_req,
   input wire logic [1:0] acc_space,
   output logic acc_allow, // combinational
   // pin use and mode status
   output logic ext_bus_enable,
   output logic [NUM_PORTS-1:0] port_free,
   output logic [1:0] mode,
   output logic rom_locked,
   // system reset and ram retention
   output logic sys_rst_n,
   output logic ram_keep
);
   import mode_ctrl_pkg::*;

   // ==========================================
   // reset release and pin sync
   // synchroniser flops; only the raw reset clears them
   typedef struct packed
   {
      logic [1:0] rst_sync; // reset release chain
      logic [1:0] pin_sync; // strap level chain
   } sync_t;

   // mode state; hardware and software reset both clear it
   typedef struct packed
   {
      logic [7:0] pm; // register image
      logic rom_lock; // strap saw the pin high
      logic strap_done; // strap taken since the last reset
   } core_t;

   sync_t sy_reg;
   sync_t sy_next;
   core_t st_reg;
   core_t st_next;
   logic hw_rst_n; // synchronised hardware reset
   logic soft_rst; // stretched software reset
   logic core_rst_n; // combined reset for the mode state
   logic soft_trig; // one-cycle trigger from the register write

   // ==========================================
   // decode helpers
   // modes that hand port pins to the external bus
   function automatic logic bus_lent(input logic [1:0] m);
      return (m != MODE_SINGLE);
   endfunction

   // register image as stored; the reset bit never sticks
   function automatic logic [7:0] stored_image(input logic [7:0] d,
      input logic [1:0] keep_mode);
      logic [7:0] img;
      img = d;
      img[PM_SOFT_RST_BIT] = 1'b0;
      // code 10 is refused; the field keeps the mode in force
      if (d[PM_MODE_HI:PM_MODE_LO] == MODE_BAD)
         img[PM_MODE_HI:PM_MODE_LO] = keep_mode;
      return img;
   endfunction

   // one access judged against mode and rom lock
   // unknown space codes are refused rather than guessed
   function automatic logic space_open(input logic [1:0] space,
      input logic [1:0] m,
      input logic lock);
      logic ok;
      ok = 1'b0;
      case (space)
         SPACE_SFR: ok = 1'b1;
         SPACE_RAM: ok = 1'b1;
         SPACE_ROM: ok = !lock;
         SPACE_EXT: ok = bus_lent(m);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // ==========================================
   // synchronisers
   // two-stage synchronisers; first stages feed only second stages
   always_comb
   begin
      sy_next = sy_reg;
      // reset chain shifts in ones after release
      sy_next.rst_sync = {sy_reg.rst_sync[0], 1'b1};
      sy_next.pin_sync = {sy_reg.pin_sync[0], boot_mode_pin};
   end

   // raw reset clears both chains; release ripples through two edges
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         sy_reg <= '0;
      else
         sy_reg <= sy_next;
   end

   // the rest of the block sees only this released copy
   // it rises two edges after release; the strap follows one edge later
   assign hw_rst_n = sy_reg.rst_sync[1];

   // ==========================================
   // software reset
   // strobe and bit 3 in one cycle fire the reset
   assign soft_trig = pm_wr && pm_wdata[PM_SOFT_RST_BIT];

   // pulse stretcher; only the hardware reset clears it
   soft_reset_gen u_soft_reset_gen
   (
      .ref_clk(ref_clk),
      .rst_n(hw_rst_n),
      .trigger(soft_trig),
      .soft_rst(soft_rst)
   );

   // soft reset drives the same system reset as hardware; ram excluded
   // both sources are flops, so the combined reset cannot glitch
   // ram sits outside this block and holds while ram_keep is high
   assign core_rst_n = hw_rst_n && !soft_rst;
   assign sys_rst_n = core_rst_n;
   assign ram_keep = soft_rst;

   // ==========================================
   // mode register
   // strap first after each reset, software writes afterwards
   always_comb
   begin
      st_next = st_reg; // default: hold
      if (!st_reg.strap_done)
      begin
         // strap caught at first edge after reset release
         st_next.strap_done = 1'b1;
         // pin high: rom hidden until the next reset of either kind
         st_next.rom_lock = sy_reg.pin_sync[1];
         if (sy_reg.pin_sync[1])
            st_next.pm[PM_MODE_HI:PM_MODE_LO] = MODE_MICRO;
         else
            st_next.pm[PM_MODE_HI:PM_MODE_LO] = MODE_SINGLE;
      end
      else if (pm_wr && !pm_wdata[PM_SOFT_RST_BIT])
      begin
         // a write with bit 3 set fires the reset and stores nothing
         // field write picks the mode whatever the pin level; 01 = expansion
         // other bits land in the same write; software orders its writes
         st_next.pm = stored_image(pm_wdata, st_reg.pm[PM_MODE_HI:PM_MODE_LO]);
      end
      // with no write the image simply holds, so readback stays valid
   end

   // cleared by either reset; the strap is taken again after each
   always_ff @(posedge ref_clk or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         st_reg.pm <= PM_RESET_VAL;
         st_reg.rom_lock <= 1'b0;
         st_reg.strap_done <= 1'b0;
      end
      else
         st_reg <= st_next;
   end

   // ==========================================
   // status outputs
   // mode in force, straight from the register image
   assign mode = st_reg.pm[PM_MODE_HI:PM_MODE_LO];
   // readback is the stored image; bit 3 is never stored
   assign pm_rdata = st_reg.pm;
   // rom stays hidden once the strap saw the pin high
   assign rom_locked = st_reg.rom_lock || (mode == MODE_MICRO);

   // ==========================================
   // access decode
   // nothing is allowed until the strap has set the mode
   always_comb
   begin
      acc_allow = 1'b0;
      if (acc_req && st_reg.strap_done)
         acc_allow = space_open(acc_space, mode, rom_locked);
   end

   // bus pins lent out outside single-chip mode
   // ports fall back to general use in single-chip mode
   assign ext_bus_enable = st_reg.strap_done && bus_lent(mode);
   assign port_free = ext_bus_enable ? '0 : '1;
endmodule
`default_nettype wire

// [tb/mode_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ====
// checks on mode outputs
module mode_assertions
   import mode_ctrl_pkg::*;
#(parameter int NUM_PORTS = 11)
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic pm_wr,
   input wire logic [7:0] pm_wdata,
   input wire logic acc_req,
   input wire logic [1:0] acc_space,
   input wire logic acc_allow,
   input wire logic ext_bus_enable,
   input wire logic [NUM_PORTS-1:0] port_free,
   input wire logic [1:0] mode,
   input wire logic rom_locked,
   input wire logic sys_rst_n,
   input wire logic ram_keep
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // access only judged outside system reset
   wire logic go = acc_req && sys_rst_n;
   single_ext_a: assert property (go && mode == MODE_SINGLE && acc_space == SPACE_EXT
      |-> !acc_allow) else $error("ext access in single-chip");
   micro_rom_a: assert property (go && mode == MODE_MICRO && acc_space == SPACE_ROM
      |-> !acc_allow) else $error("rom access in micro");
   rom_lock_a: assert property (go && rom_locked && acc_space == SPACE_ROM
      |-> !acc_allow) else $error("locked rom reached");
   expand_all_a: assert property (go && mode == MODE_EXPAND && !rom_locked
      |-> acc_allow) else $error("expansion access refused");
   bus_pins_a: assert property (sys_rst_n |-> ext_bus_enable == (mode != MODE_SINGLE)
      && port_free == {NUM_PORTS{mode == MODE_SINGLE}}) else $error("pin use wrong");
   mode_wr_a: assert property (pm_wr && !pm_wdata[3] && pm_wdata[1:0] != MODE_BAD
      |=> mode == $past(pm_wdata[1:0])) else $error("mode write lost");
   bad_code_a: assert property (pm_wr && !pm_wdata[3] && pm_wdata[1:0] == MODE_BAD
      |=> $stable(mode)) else $error("bad code taken");
   soft_rst_a: assert property (pm_wr && pm_wdata[3] && sys_rst_n
      |=> (!sys_rst_n && ram_keep) [*4] ##1 sys_rst_n) else $error("soft reset wrong");
endmodule
bind processor_mode_and_soft_reset mode_assertions #(.NUM_PORTS(NUM_PORTS)) chk
(
   .ref_clk(ref_clk),
   .resetn(resetn),
   .pm_wr(pm_wr),
   .pm_wdata(pm_wdata),
   .acc_req(acc_req),
   .acc_space(acc_space),
   .acc_allow(acc_allow),
   .ext_bus_enable(ext_bus_enable),
   .port_free(port_free),
   .mode(mode),
   .rom_locked(rom_locked),
   .sys_rst_n(sys_rst_n),
   .ram_keep(ram_keep)
);
`default_nettype wire

// [tb/mode_writer.sv]
`timescale 1ns/1ps
`default_nettype none
// ====
// software side writing the mode register
module mode_writer
(
   input wire logic ref_clk,
   output logic pm_wr,
   output logic [7:0] pm_wdata
);
   initial pm_wr = 1'b0;
   initial pm_wdata = 8'h00;
   // other bits before mode field, code 10 only to test refusal, never from rom
   task automatic wr(input logic [7:0] d);
      @(posedge ref_clk) #1;
      pm_wr = 1'b1;
      pm_wdata = d;
      @(posedge ref_clk) #1;
      pm_wr = 1'b0;
      pm_wdata = ~d;
   endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED %0t %h %h", $time, a, b); end end
// ====
// bench for mode control
module tb_top;
   import mode_ctrl_pkg::*;
   logic ref_clk;
   logic resetn;
   logic boot_mode_pin;
   logic acc_req;
   logic [1:0] acc_space;
   wire logic pm_wr, acc_allow, ext_bus_enable, rom_locked, sys_rst_n, ram_keep;
   wire logic [7:0] pm_wdata, pm_rdata;
   wire logic [10:0] port_free;
   wire logic [1:0] mode;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   always #25 ref_clk = ~ref_clk;
   mode_writer sw
   (
      .ref_clk(ref_clk),
      .pm_wr(pm_wr),
      .pm_wdata(pm_wdata)
   );
   processor_mode_and_soft_reset #(.NUM_PORTS(11)) dut
   (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .boot_mode_pin(boot_mode_pin),
      .pm_wr(pm_wr),
      .pm_wdata(pm_wdata),
      .pm_rdata(pm_rdata),
      .acc_req(acc_req),
      .acc_space(acc_space),
      .acc_allow(acc_allow),
      .ext_bus_enable(ext_bus_enable),
      .port_free(port_free),
      .mode(mode),
      .rom_locked(rom_locked),
      .sys_rst_n(sys_rst_n),
      .ram_keep(ram_keep)
   );
   task automatic conclude();
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // hang guard
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         err_count++;
         conclude();
      end
   end
   task automatic hw_reset(input logic pin);
      boot_mode_pin = pin;
      resetn = 1'b0;
      repeat (6) @(posedge ref_clk);
      #1 resetn = 1'b1;
      repeat (8) @(posedge ref_clk);
   endtask
   // exp bit per space: sfr, ram, rom, ext
   task automatic spaces(input logic [3:0] exp);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge ref_clk) #1;
         acc_req = 1'b1;
         acc_space = 2'(i);
         #10 `CHK(acc_allow, exp[i])
      end
      @(posedge ref_clk) #1;
      acc_req = 1'b0;
   endtask
   task automatic mode_is(input logic [1:0] m);
      `CHK(mode, m)
      `CHK(pm_rdata[1:0], m)
      `CHK(ext_bus_enable, m != MODE_SINGLE)
      `CHK(port_free, {11{m == MODE_SINGLE}})
   endtask
   // boot pin low: single-chip start, expansion, micro, refused code
   task automatic boot_low();
      hw_reset(1'b0);
      mode_is(MODE_SINGLE);
      spaces(4'b0111);
      sw.wr(8'h01);
      mode_is(MODE_EXPAND);
      spaces(4'b1111);
      sw.wr(8'h03);
      sw.wr(8'h02);
      mode_is(MODE_MICRO);
      `CHK(pm_rdata, 8'h03)
      spaces(4'b1011);
   endtask
   // software reset: pulse length, ram kept, strap taken again
   task automatic soft_reset();
      sw.wr(8'h09);
      `CHK(sys_rst_n, 1'b0)
      `CHK(ram_keep, 1'b1)
      repeat (SOFT_RST_CYCLES - 1) @(posedge ref_clk);
      #1 `CHK(sys_rst_n, 1'b0)
      @(posedge ref_clk);
      #1 `CHK(sys_rst_n, 1'b1)
      `CHK(ram_keep, 1'b0)
      repeat (2) @(posedge ref_clk);
      #1 mode_is(MODE_SINGLE);
      `CHK(rom_locked, 1'b0)
   endtask
   // boot pin high: micro start, rom stays hidden in every mode
   task automatic boot_high();
      hw_reset(1'b1);
      mode_is(MODE_MICRO);
      `CHK(rom_locked, 1'b1)
      sw.wr(8'h00);
      mode_is(MODE_SINGLE);
      `CHK(rom_locked, 1'b1)
      spaces(4'b0011);
      sw.wr(8'h40);
      sw.wr(8'h41);
      mode_is(MODE_EXPAND);
      `CHK(pm_rdata, 8'h41)
      spaces(4'b1011);
   endtask
   initial
   begin
      ref_clk = 1'b0;
      resetn = 1'b0;
      boot_mode_pin = 1'b0;
      acc_req = 1'b0;
      acc_space = 2'h0;
      boot_low();
      soft_reset();
      boot_high();
      conclude();
   end
endmodule
`default_nettype wire
